// File: iss_consts.vh
// What this block does
// R01: Transfer-complete flag low while byte shifts
// R02: Byte done sets flag and raises interrupt
// R03: Matching master address sets address-match flag
// R04: Mismatched address keeps address-match flag low
// R05: START sets bus-busy, STOP clears it
// R06: Drive ack control bit on ninth clock
// R07: Sample master ack into received-ack flag
// R08: Re-enable resets flags, keeps control bits
// R09: Status bits ignore writes; control bits store
`ifndef ISS_CONSTS_VH
`define ISS_CONSTS_VH

// Register indices on the plain register port
`define ISS_ADDR_W 3
`define ISS_IDX_STATUS_CTRL 3'h0
`define ISS_IDX_OWN_ADDR 3'h1
`define ISS_IDX_ENABLE 3'h2
`define ISS_IDX_INT_STATUS 3'h3
`define ISS_IDX_INT_ENABLE 3'h4
`define ISS_IDX_INT_CLEAR 3'h5

// Field positions of the status/control register
`define ISS_BIT_BYTE_DONE 7
`define ISS_BIT_ADDR_MATCH 6
`define ISS_BIT_BUS_BUSY 5
`define ISS_BIT_TX_DIR 4
`define ISS_BIT_ACK_OUT 3
`define ISS_BIT_READ_REQ 2
`define ISS_BIT_WAKE_EN 1
`define ISS_BIT_ACK_IN 0

// Software-writable bits of the status/control register
`define ISS_CTRL_WR_MASK 8'h1a

// Enable register field
`define ISS_BIT_IF_EN 0

// Interrupt status layout
`define ISS_INT_W 4
`define ISS_INT_BYTE_DONE 0
`define ISS_INT_ADDR_MATCH 1
`define ISS_INT_START 2
`define ISS_INT_STOP 3

// Reset values
`define ISS_RST_BYTE_DONE 1'b1
`define ISS_RST_ACK_IN 1'b1
`define ISS_RST_OWN_ADDR 8'h00

// Bit counter positions within one nine-clock byte slot
`define ISS_CNT_W 4
`define ISS_CNT_LAST_DATA 4'h7
`define ISS_CNT_ACK 4'h8
`define ISS_CNT_FIRST 4'h0

`endif

// File: iss_bus_watch.v
`timescale 1ns/100ps
`default_nettype none
`include "iss_consts.vh"

module iss_bus_watch (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Interface on/off
    input wire enable,
    // Sampled bus lines
    input wire scl_in,
    input wire sda_in,
    // Registered bus events
    output reg start_pulse,
    output reg stop_pulse,
    output reg scl_fall_pulse,
    output reg byte_pulse,
    output reg ack_rise_pulse,
    output reg [`ISS_CNT_W-1:0] bit_cnt,
    output reg [7:0] shift_byte
);

    reg scl_q; // Previous clock line
    reg sda_q; // Previous data line
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    // Edge and condition detection
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign start_det = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_det = scl_in & scl_q & ~sda_q & sda_in;

    // Line history
    always @(posedge clk) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Bit counting and shifting
    always @(posedge clk) begin
        if (!resetn || !enable) begin
            start_pulse <= 1'b0;
            stop_pulse <= 1'b0;
            scl_fall_pulse <= 1'b0;
            byte_pulse <= 1'b0;
            ack_rise_pulse <= 1'b0;
            bit_cnt <= `ISS_CNT_FIRST;
            shift_byte <= 8'h00;
        end else begin
            start_pulse <= start_det;
            stop_pulse <= stop_det;
            scl_fall_pulse <= scl_fall;
            byte_pulse <= scl_rise && (bit_cnt == `ISS_CNT_LAST_DATA);
            ack_rise_pulse <= scl_rise && (bit_cnt == `ISS_CNT_ACK);
            if (start_det) begin
                // Fresh slot after a START
                bit_cnt <= `ISS_CNT_FIRST;
            end else if (scl_rise) begin
                if (bit_cnt == `ISS_CNT_ACK) begin
                    bit_cnt <= `ISS_CNT_FIRST;
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                    shift_byte <= {shift_byte[6:0], sda_in};
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: iss_status_ctrl.v
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "iss_consts.vh"

module iss_status_ctrl (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Register port
    input wire [`ISS_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Serial bus pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // Data path to the byte holder
    input wire [7:0] tx_byte,
    output reg [7:0] rx_byte,
    output reg rx_valid,
    // Interrupt and wake-up
    output reg irq,
    output reg addr_wake
);

    // Status and control bits
    reg byte_done_flag_reg;
    reg addr_match_flag_reg;
    reg bus_busy_flag_reg;
    reg tx_direction_select_reg;
    reg ack_out_control_reg;
    reg master_read_request_flag_reg;
    reg addr_match_wakeup_enable_reg;
    reg ack_in_flag_reg;
    // Other software registers
    reg [7:0] own_addr_reg;
    reg serial_if_enable_reg;
    reg enable_q_reg; // Enable one cycle ago
    reg [`ISS_INT_W-1:0] int_stat_reg;
    reg [`ISS_INT_W-1:0] int_en_reg;
    reg [`ISS_INT_W-1:0] int_stat_next;
    reg [`ISS_INT_W-1:0] int_event;
    // Transfer state
    reg first_byte_reg; // Next byte is the address
    reg active_reg; // Addressed in this transfer
    reg ack_due_reg; // Byte just received wants an ack
    reg sending_reg; // Slave drives data bits
    reg [7:0] tx_shift_reg; // Outgoing byte
    // Bus events
    wire start_pulse;
    wire stop_pulse;
    wire scl_fall_pulse;
    wire byte_pulse;
    wire ack_rise_pulse;
    wire [`ISS_CNT_W-1:0] bit_cnt;
    wire [7:0] shift_byte;
    wire enable_rise;
    wire addr_hit;
    wire [7:0] status_ctrl_value;

    // Address equality of the seven upper bits
    function addr_equal;
        input [7:0] a;
        input [7:0] b;
        begin
            addr_equal = (a[7:1] == b[7:1]);
        end
    endfunction

    // Bus condition and bit tracker
    iss_bus_watch u_watch (
        .clk(clk),
        .resetn(resetn),
        .enable(serial_if_enable_reg),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .start_pulse(start_pulse),
        .stop_pulse(stop_pulse),
        .scl_fall_pulse(scl_fall_pulse),
        .byte_pulse(byte_pulse),
        .ack_rise_pulse(ack_rise_pulse),
        .bit_cnt(bit_cnt),
        .shift_byte(shift_byte)
    );

    assign enable_rise = serial_if_enable_reg & ~enable_q_reg;
    assign addr_hit = addr_equal(shift_byte, own_addr_reg);

    // Packed view of the status/control register
    assign status_ctrl_value = {byte_done_flag_reg, addr_match_flag_reg,
        bus_busy_flag_reg, tx_direction_select_reg, ack_out_control_reg,
        master_read_request_flag_reg, addr_match_wakeup_enable_reg,
        ack_in_flag_reg};

    // Software-owned control bits
    always @(posedge clk) begin
        if (!resetn) begin
            tx_direction_select_reg <= 1'b0;
            ack_out_control_reg <= 1'b0;
            addr_match_wakeup_enable_reg <= 1'b0;
            own_addr_reg <= `ISS_RST_OWN_ADDR;
            serial_if_enable_reg <= 1'b0;
            int_en_reg <= {`ISS_INT_W{1'b0}};
            enable_q_reg <= 1'b0;
        end else begin
            enable_q_reg <= serial_if_enable_reg;
            if (reg_wr) begin
                case (reg_addr)
                    `ISS_IDX_STATUS_CTRL: begin
                        // Only the writable fields take the value
                        tx_direction_select_reg <=
                            reg_wdata[`ISS_BIT_TX_DIR]; // R09
                        ack_out_control_reg <=
                            reg_wdata[`ISS_BIT_ACK_OUT]; // R09
                        addr_match_wakeup_enable_reg <=
                            reg_wdata[`ISS_BIT_WAKE_EN]; // R09
                    end
                    `ISS_IDX_OWN_ADDR: begin
                        own_addr_reg <= reg_wdata;
                    end
                    `ISS_IDX_ENABLE: begin
                        serial_if_enable_reg <= reg_wdata[`ISS_BIT_IF_EN];
                    end
                    `ISS_IDX_INT_ENABLE: begin
                        int_en_reg <= reg_wdata[`ISS_INT_W-1:0];
                    end
                    default: begin
                        // Other indices hold nothing writable here
                    end
                endcase
            end
        end
    end

    // Hardware flags and transfer state
    always @(posedge clk) begin
        if (!resetn || enable_rise) begin
            // Re-enable restores flags, control bits stay
            byte_done_flag_reg <= `ISS_RST_BYTE_DONE; // R08
            addr_match_flag_reg <= 1'b0; // R08
            bus_busy_flag_reg <= 1'b0; // R08
            master_read_request_flag_reg <= 1'b0; // R08
            ack_in_flag_reg <= `ISS_RST_ACK_IN; // R08
            first_byte_reg <= 1'b0;
            active_reg <= 1'b0;
            ack_due_reg <= 1'b0;
            sending_reg <= 1'b0;
            tx_shift_reg <= 8'h00;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (!serial_if_enable_reg) begin
            // Disabled interface lets go of the line
            sda_oe <= 1'b0;
            sending_reg <= 1'b0;
            rx_valid <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            rx_valid <= 1'b0;
            if (start_pulse) begin
                // New transfer, address byte follows
                bus_busy_flag_reg <= 1'b1; // R05
                first_byte_reg <= 1'b1;
                active_reg <= 1'b0;
                addr_match_flag_reg <= 1'b0;
                ack_due_reg <= 1'b0;
                sending_reg <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_pulse) begin
                // Bus free again
                bus_busy_flag_reg <= 1'b0; // R05
                active_reg <= 1'b0;
                first_byte_reg <= 1'b0;
                ack_due_reg <= 1'b0;
                sending_reg <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                // First clock of a byte clears the done flag
                if (scl_fall_pulse && bit_cnt == `ISS_CNT_FIRST &&
                    (active_reg || first_byte_reg)) begin
                    byte_done_flag_reg <= 1'b0; // R01
                end
                if (byte_pulse && first_byte_reg) begin
                    // Address byte complete
                    first_byte_reg <= 1'b0;
                    if (addr_hit) begin
                        addr_match_flag_reg <= 1'b1; // R03
                        master_read_request_flag_reg <= shift_byte[0];
                        active_reg <= 1'b1;
                        ack_due_reg <= 1'b1;
                        byte_done_flag_reg <= 1'b1; // R02
                    end else begin
                        addr_match_flag_reg <= 1'b0; // R04
                        active_reg <= 1'b0;
                        ack_due_reg <= 1'b0;
                    end
                end else if (byte_pulse && active_reg) begin
                    // Data byte complete in either direction
                    byte_done_flag_reg <= 1'b1; // R02
                    ack_due_reg <= ~tx_direction_select_reg;
                    if (!tx_direction_select_reg) begin
                        rx_byte <= shift_byte;
                        rx_valid <= 1'b1;
                    end
                end
                if (ack_rise_pulse && active_reg && !ack_due_reg &&
                    tx_direction_select_reg) begin
                    // Master answer to our byte
                    ack_in_flag_reg <= sda_in; // R07
                end
                if (scl_fall_pulse) begin
                    if (bit_cnt == `ISS_CNT_ACK) begin
                        // Ninth clock: ack slot
                        sda_oe <= ack_due_reg & ~ack_out_control_reg; // R06
                        sending_reg <= 1'b0;
                    end else if (bit_cnt == `ISS_CNT_FIRST) begin
                        // Ack slot over; maybe start sending
                        ack_due_reg <= 1'b0;
                        if (active_reg && tx_direction_select_reg &&
                            (sending_reg || ack_due_reg ||
                            !ack_in_flag_reg)) begin
                            sending_reg <= 1'b1;
                            tx_shift_reg <= {tx_byte[6:0], 1'b0};
                            sda_oe <= ~tx_byte[7];
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end else if (sending_reg) begin
                        // Next outgoing bit, low by driving
                        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                        sda_oe <= ~tx_shift_reg[7];
                    end
                end
                if (ack_rise_pulse && !ack_due_reg && sending_reg) begin
                    // Refusal from the master ends sending
                    sending_reg <= ~sda_in; // R07
                end
            end
        end
    end

    // Events for the interrupt status
    always @* begin
        int_event = {`ISS_INT_W{1'b0}};
        if (serial_if_enable_reg && !enable_rise) begin
            int_event[`ISS_INT_BYTE_DONE] = byte_pulse &&
                ((first_byte_reg && addr_hit) ||
                (active_reg && !first_byte_reg)); // R02
            int_event[`ISS_INT_ADDR_MATCH] = byte_pulse &&
                first_byte_reg && addr_hit;
            int_event[`ISS_INT_START] = start_pulse;
            int_event[`ISS_INT_STOP] = stop_pulse && !start_pulse;
        end
    end

    // Sticky status: a new event wins over a clear
    always @* begin
        int_stat_next = int_stat_reg;
        if (reg_wr && reg_addr == `ISS_IDX_INT_CLEAR) begin
            int_stat_next = int_stat_next & ~reg_wdata[`ISS_INT_W-1:0];
        end
        int_stat_next = int_stat_next | int_event;
    end

    // Interrupt status, line and wake-up request
    always @(posedge clk) begin
        if (!resetn) begin
            int_stat_reg <= {`ISS_INT_W{1'b0}};
            irq <= 1'b0;
            addr_wake <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            irq <= |(int_stat_next & int_en_reg); // R02
            addr_wake <= addr_match_wakeup_enable_reg &
                int_event[`ISS_INT_ADDR_MATCH];
        end
    end

    // Read data, one cycle after the read strobe
    always @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ISS_IDX_STATUS_CTRL: begin
                    reg_rdata <= status_ctrl_value;
                end
                `ISS_IDX_OWN_ADDR: begin
                    reg_rdata <= own_addr_reg;
                end
                `ISS_IDX_ENABLE: begin
                    reg_rdata <= {7'h00, serial_if_enable_reg};
                end
                `ISS_IDX_INT_STATUS: begin
                    reg_rdata <= {4'h0, int_stat_reg};
                end
                `ISS_IDX_INT_ENABLE: begin
                    reg_rdata <= {4'h0, int_en_reg};
                end
                default: begin
                    // Clear register and holes read zero
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// File: iss_status_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "iss_consts.vh"
module iss_status_ctrl_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [`ISS_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Byte path
    input wire logic [7:0] tx_byte,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    // Interrupt and wake-up
    input wire logic irq,
    input wire logic addr_wake
);
    // All checks share the system clock and its reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_rdata_unmapped: assert property ($past(reg_rd) &&
        $past(reg_addr) >= 3'h5 |-> reg_rdata == 8'h00)
        else $error("unmapped or clear index read not zero");
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("data output value not zero");
    a_oe_scl_low: assert property ($changed(sda_oe) |->
        !scl_in && !$past(scl_in))
        else $error("data line drive changed while clock high");
    a_rx_one_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("byte valid longer than one cycle");
    a_rx_clock_high: assert property (rx_valid |-> scl_in && $past(scl_in))
        else $error("byte completed outside eighth clock high");
    a_wake_pulse: assert property (addr_wake |-> scl_in ##1 !addr_wake)
        else $error("wake pulse malformed");
    a_irq_masked: assert property (reg_wr &&
        reg_addr == `ISS_IDX_INT_ENABLE && reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("interrupt stays high with all enables off");

    // Main scenarios reached
    c_rx: cover property (rx_valid);
    c_wake: cover property (addr_wake);
    c_ack_drive: cover property ($rose(sda_oe));
    c_irq_drop: cover property ($fell(irq));
endmodule
`default_nettype wire

// File: iss_i2c_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module iss_i2c_mdl (
    // Clock
    input wire logic clk,
    // Resolved data line
    input wire logic sda,
    // Driven clock line and data pull-down, low pulls
    output logic scl,
    output logic sda_drv_n
);
    // Quarter bit period in system clocks
    localparam int PH = 3;
    initial begin
        scl = 1'b1;
        sda_drv_n = 1'b1;
    end
    // Wait a quarter bit period
    task automatic half;
        repeat (PH) @(posedge clk);
    endtask
    // Data falls while clock high
    task automatic start;
        sda_drv_n <= 1'b1;
        half;
        scl <= 1'b1;
        half;
        sda_drv_n <= 1'b0;
        half;
    endtask
    // Data rises while clock high
    task automatic stop;
        scl <= 1'b0;
        half;
        sda_drv_n <= 1'b0;
        half;
        scl <= 1'b1;
        half;
        sda_drv_n <= 1'b1;
        half;
    endtask
    // One clock: data set mid-low, sampled mid-high, ends clock high
    task automatic clk_bit(input logic b, output logic r);
        scl <= 1'b0;
        half;
        sda_drv_n <= b;
        half;
        scl <= 1'b1;
        half;
        r = sda;
        half;
    endtask
endmodule
`default_nettype wire

// File: iss_status_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "iss_consts.vh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    n_fail++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end end
module iss_status_ctrl_tb;
    // Design inputs
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [`ISS_ADDR_W-1:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    // Design outputs
    wire [7:0] reg_rdata;
    wire [7:0] rx_byte;
    wire sda_out, sda_oe, rx_valid, irq, addr_wake;
    // Bus lines, data line pulled up
    wire scl, sda_drv_n;
    wire sda = sda_drv_n & ~sda_oe;
    // Bench state and expected byte queue
    int n_fail = 0;
    int n_checks = 0;
    logic [7:0] own, ctrl, v, dat, exp_b;
    logic ack, r;
    logic wake_seen = 1'b0;
    logic [7:0] exp_q[$];

    always #10 clk = ~clk;

    // Latch any address wake-up pulse for a later look
    always @(posedge clk) begin
        if (addr_wake)
            wake_seen <= 1'b1;
    end

    iss_status_ctrl dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
        .tx_byte, .rx_byte, .rx_valid, .irq, .addr_wake);
    iss_i2c_mdl mdl (.clk, .sda, .scl, .sda_drv_n);

    // One-cycle register write
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
        rd(a, v);
        `CHK("register", e, v)
    endtask
    // Flags {done, match, busy, read_req, ack_in}; control from ctrl
    task automatic chk_st(input logic [4:0] f);
        rd(`ISS_IDX_STATUS_CTRL, v);
        `CHK("status", {f[4:2], ctrl[4:3], f[1], ctrl[1], f[0]}, v)
    endtask
    // Master writes a byte; optional status look in mid-byte
    task automatic wbyte(input logic [7:0] d, input logic mid);
        for (int i = 7; i >= 0; i--) begin
            mdl.clk_bit(d[i], r);
            if (mid && i == 4)
                chk_st(5'b01101);
        end
        mdl.clk_bit(1'b1, ack);
    endtask
    // Master reads a byte and answers with m
    task automatic rbyte(input logic m);
        for (int i = 0; i < 8; i++) begin
            mdl.clk_bit(1'b1, r);
            dat = {dat[6:0], r};
        end
        mdl.clk_bit(m, r);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog against a hung bus
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        void'($urandom(17134));
        ctrl = 8'h00;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        chk_st(5'b10001);
        wr(3'h0, 8'hff);
        ctrl = 8'h1a;
        chk_st(5'b10001);
        wr(3'h3, 8'hff);
        chk_reg(3'h3, 8'h00);
        chk_reg(3'h5, 8'h00);
        chk_reg(3'h6, 8'h00);
        own = 8'($urandom) & 8'hfe;
        wr(3'h1, own);
        chk_reg(3'h1, own);
        wr(3'h2, 8'h01);
        wr(3'h4, 8'h0f);
        ctrl = 8'h02;
        wr(3'h0, ctrl);
        // Foreign address
        mdl.start;
        chk_st(5'b10101);
        wbyte(own ^ 8'h02, 1'b0);
        `CHK("ack", 1'b1, ack)
        chk_st(5'b00101);
        `CHK("wake", 1'b0, wake_seen)
        mdl.stop;
        chk_st(5'b00001);
        chk_reg(3'h3, 8'h0c);
        wr(3'h5, 8'h0f);
        chk_reg(3'h3, 8'h00);
        // Own address, master writes
        mdl.start;
        wbyte(own, 1'b0);
        `CHK("ack", 1'b0, ack)
        chk_st(5'b11101);
        `CHK("wake", 1'b1, wake_seen)
        dat = 8'($urandom);
        exp_q.push_back(dat);
        wbyte(dat, 1'b1);
        `CHK("ack", 1'b0, ack)
        exp_b = exp_q.pop_front();
        `CHK("rx byte", exp_b, rx_byte)
        chk_st(5'b11101);
        chk_reg(3'h3, 8'h07);
        `CHK("irq", 1'b1, irq)
        ctrl = 8'h0a;
        wr(3'h0, ctrl);
        wbyte(~dat, 1'b0);
        `CHK("ack", 1'b1, ack)
        mdl.stop;
        chk_st(5'b01001);
        // Own address, master reads
        ctrl = 8'h12;
        wr(3'h0, ctrl);
        dat = 8'($urandom);
        exp_q.push_back(dat);
        exp_q.push_back(dat);
        tx_byte <= dat;
        mdl.start;
        wbyte(own | 8'h01, 1'b0);
        `CHK("ack", 1'b0, ack)
        chk_st(5'b11111);
        rbyte(1'b0);
        exp_b = exp_q.pop_front();
        `CHK("tx byte", exp_b, dat)
        chk_st(5'b11110);
        rbyte(1'b1);
        exp_b = exp_q.pop_front();
        `CHK("tx byte", exp_b, dat)
        chk_st(5'b11111);
        mdl.stop;
        chk_st(5'b01011);
        // Re-enable in mid-transfer, slave never drives the line
        ctrl = 8'h0a;
        wr(3'h0, ctrl);
        mdl.start;
        wbyte(own, 1'b0);
        mdl.clk_bit(1'b0, r);
        wr(3'h2, 8'h00);
        wr(3'h2, 8'h01);
        chk_st(5'b10001);
        mdl.stop;
        chk_st(5'b10001);
        // Interrupt masking and clearing
        wr(3'h4, 8'h00);
        repeat (2) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        wr(3'h4, 8'h0f);
        repeat (2) @(negedge clk);
        `CHK("irq", 1'b1, irq)
        wr(3'h5, 8'h0f);
        repeat (2) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        tally_and_finish;
    end
endmodule
bind iss_status_ctrl iss_status_ctrl_assertions u_chk (.clk, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_in, .sda_in,
    .sda_out, .sda_oe, .tx_byte, .rx_byte, .rx_valid, .irq, .addr_wake);
`default_nettype wire
